// ### design/port_role_pkg.sv
// Shared constants and types for the port-role control block
package port_role_pkg;

	// Port role select field encodings
	localparam logic [1:0] ROLE_DUAL   = 2'h0;
	localparam logic [1:0] ROLE_SINK   = 2'h1;
	localparam logic [1:0] ROLE_SOURCE = 2'h2;
	localparam logic [1:0] ROLE_RESET  = ROLE_DUAL;

	// Slave addresses selected by the bus id strap
	localparam logic [6:0] ADDR_STRAP_LOW  = 7'h47;
	localparam logic [6:0] ADDR_STRAP_HIGH = 7'h67;

	// Clock and dual-role toggle timing
	localparam int CLK_FREQ_KHZ      = 40000;
	localparam int TOGGLE_TIME_US    = 50;
	localparam int TOGGLE_CYCLES     = (TOGGLE_TIME_US * CLK_FREQ_KHZ) / 1000;
	localparam int TOGGLE_CNT_W      = 12;
	localparam logic [TOGGLE_CNT_W-1:0] TOGGLE_LAST =
		TOGGLE_CNT_W'(TOGGLE_CYCLES - 1);

	// Attach state machine, one-hot
	typedef enum logic [3:0] {
		ST_UNATT_SNK = 4'h1,
		ST_UNATT_SRC = 4'h2,
		ST_ATT_SNK   = 4'h4,
		ST_ATT_SRC   = 4'h8
	} attach_state_t;

endpackage

// ### design/pin_sync_if.sv
// Synchronised pin levels passed from the pin synchroniser to the core
interface pin_sync_if;
	logic enable_low;
	logic vbus_present;
	logic cc1_active;
	logic cc2_active;

	modport sync_side (output enable_low, output vbus_present, output cc1_active,
		output cc2_active);
	modport core_side (input enable_low, input vbus_present, input cc1_active,
		input cc2_active);
endinterface

// ### design/pin_synchroniser.sv
// Three-stage synchronisers with agreement filter for the external pins
module pin_synchroniser (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// Raw pins
	input  wire logic [3:0]  pins_i,
	// Filtered levels
	pin_sync_if.sync_side    sync
);

	logic [3:0] stage1;
	logic [3:0] stage2;
	logic [3:0] stage3;
	logic [3:0] level;

	// Enable pin rests high (disabled) through reset
	localparam logic [3:0] PIN_RESET = 4'h1;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			stage1 <= PIN_RESET;
			stage2 <= PIN_RESET;
			stage3 <= PIN_RESET;
		end else begin
			stage1 <= pins_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A change counts once the second and third stages agree
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			level <= PIN_RESET;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (stage2[i] == stage3[i]) begin
					level[i] <= stage3[i];
				end
			end
		end
	end

	assign sync.enable_low   = level[0];
	assign sync.vbus_present = level[1];
	assign sync.cc1_active   = level[2];
	assign sync.cc2_active   = level[3];

endmodule

// ### design/typec_port_role_control.sv
// Port-role selection, attach sequencing and orientation for a Type-C CC port

// Contract
// [RULE1] A role select value of 01 makes the port a fixed upstream-facing sink.
// [RULE2] A role select write, a soft reset request or a falling enable pin ends the fixed role; the code keeps ROLE_SELECT_O on a falling enable pin.
// [RULE3] Any change of host-visible state pulls the open-drain change alert low.
// [RULE4] The orientation output steers an external lane mux to match the plug orientation.
// [RULE5] The orientation bit names the CC pin in use, reading 0 for CC2 and 1 for CC1 when swapped.
// [RULE6] A pulled strap selects management mode, with address 0x47 when the strap is low.
// [RULE7] Without power or in reset the port shows sink pulldowns on both CC pins.
// [RULE8] After power-on reset with enable low the port starts as unattached sink and toggles.
// [RULE9] Host software writes the role select field to leave dual-role operation.
// [RULE10] Unattached, a source watches the CC pins and a sink watches VBUS for attach.
// [RULE11] The port reaches an attached state only after an attach is detected.
// [RULE12] A role select value of 10 makes the port a fixed downstream-facing source.
module typec_port_role_control (
	// Clock and reset
	input  wire logic       CORE_CLK_I,
	input  wire logic       RESET_I,
	// Pins
	input  wire logic       CHIP_ENABLE_LOW_I,
	input  wire logic       VBUS_DETECT_I,
	input  wire logic       CC1_ACTIVE_I,
	input  wire logic       CC2_ACTIVE_I,
	input  wire logic       BUS_ID_STRAP_PULLED_I,
	input  wire logic       BUS_ID_STRAP_HIGH_I,
	// Configuration from the host side
	input  wire logic [1:0] ROLE_SELECT_I,
	input  wire logic       ROLE_SELECT_WRITE_I,
	input  wire logic       SOFT_RESET_I,
	input  wire logic       CC_SWAPPED_I,
	input  wire logic       ALERT_CLEAR_I,
	// Status
	output logic [1:0]      ROLE_SELECT_O,
	output logic [3:0]      ATTACH_STATE_O,
	output logic            ATTACHED_O,
	output logic            PLUG_ORIENTATION_O,
	output logic            MANAGEMENT_MODE_O,
	output logic [6:0]      SLAVE_ADDRESS_O,
	// Terminations and external control
	output logic            CC_PULLDOWN_O,
	output logic            CC_PULLUP_O,
	output logic            ORIENTATION_OUT_O,
	output logic            CHANGE_ALERT_OUT_O,
	output logic            CHANGE_ALERT_OUT_OE_N_O
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	pin_sync_if pins ();

	pin_synchroniser u_sync (
		.clk_i   (CORE_CLK_I),
		.reset_i (RESET_I),
		.pins_i  ({CC2_ACTIVE_I, CC1_ACTIVE_I, VBUS_DETECT_I, CHIP_ENABLE_LOW_I}),
		.sync    (pins.sync_side)
	);

	////////////////////////////////////////////////////////////////////////////
	// Strap capture after reset release

	logic strap_done;

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			strap_done        <= 1'b0;
			MANAGEMENT_MODE_O <= 1'b0;
			SLAVE_ADDRESS_O   <= port_role_pkg::ADDR_STRAP_LOW;
		end else if (!strap_done) begin
			strap_done        <= 1'b1;
			MANAGEMENT_MODE_O <= BUS_ID_STRAP_PULLED_I;                         // [RULE6]
			SLAVE_ADDRESS_O   <= BUS_ID_STRAP_HIGH_I ? port_role_pkg::ADDR_STRAP_HIGH
				: port_role_pkg::ADDR_STRAP_LOW;                                  // [RULE6]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Role select field and role-exit events

	logic enable_low_q;
	logic enable_fall;
	logic role_exit;

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			enable_low_q <= 1'b1;
		end else begin
			enable_low_q <= pins.enable_low;
		end
	end

	assign enable_fall = enable_low_q && !pins.enable_low;
	assign role_exit   = ROLE_SELECT_WRITE_I || SOFT_RESET_I || enable_fall;   // [RULE2]

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ROLE_SELECT_O <= port_role_pkg::ROLE_RESET;
		end else if (SOFT_RESET_I) begin
			ROLE_SELECT_O <= port_role_pkg::ROLE_RESET;
		end else if (ROLE_SELECT_WRITE_I) begin
			ROLE_SELECT_O <= ROLE_SELECT_I;                                    // [RULE9]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Dual-role toggle timer

	logic [port_role_pkg::TOGGLE_CNT_W-1:0] toggle_cnt;
	logic                                   toggle_due;

	assign toggle_due = (toggle_cnt == port_role_pkg::TOGGLE_LAST);

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			toggle_cnt <= '0;
		end else if (toggle_due || role_exit) begin
			toggle_cnt <= '0;
		end else begin
			toggle_cnt <= toggle_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Attach state machine

	port_role_pkg::attach_state_t state;
	port_role_pkg::attach_state_t next_state;
	logic [1:0]                   role;
	logic                         cc_any;

	// Role in force after this cycle's write
	assign role   = ROLE_SELECT_WRITE_I ? ROLE_SELECT_I : ROLE_SELECT_O;
	assign cc_any = pins.cc1_active || pins.cc2_active;

	always_comb begin
		next_state = state;
		case (state)
			port_role_pkg::ST_UNATT_SNK: begin
				if (pins.vbus_present) begin
					next_state = port_role_pkg::ST_ATT_SNK;                    // [RULE10] [RULE11]
				end else if (role == port_role_pkg::ROLE_SOURCE) begin
					next_state = port_role_pkg::ST_UNATT_SRC;                  // [RULE12]
				end else if (role == port_role_pkg::ROLE_DUAL && toggle_due) begin
					next_state = port_role_pkg::ST_UNATT_SRC;                  // [RULE8]
				end
			end
			port_role_pkg::ST_UNATT_SRC: begin
				if (cc_any) begin
					next_state = port_role_pkg::ST_ATT_SRC;                    // [RULE10] [RULE11]
				end else if (role == port_role_pkg::ROLE_SINK) begin
					next_state = port_role_pkg::ST_UNATT_SNK;                  // [RULE1]
				end else if (role == port_role_pkg::ROLE_DUAL && toggle_due) begin
					next_state = port_role_pkg::ST_UNATT_SNK;                  // [RULE8]
				end
			end
			port_role_pkg::ST_ATT_SNK: begin
				if (!pins.vbus_present) begin
					next_state = port_role_pkg::ST_UNATT_SNK;
				end
			end
			port_role_pkg::ST_ATT_SRC: begin
				if (!cc_any) begin
					next_state = port_role_pkg::ST_UNATT_SRC;
				end
			end
			default: begin
				next_state = port_role_pkg::ST_UNATT_SNK;
			end
		endcase
		// Leaving the role restarts from the unattached state of the new role
		if (role_exit) begin
			next_state = (role == port_role_pkg::ROLE_SOURCE && !SOFT_RESET_I)
				? port_role_pkg::ST_UNATT_SRC : port_role_pkg::ST_UNATT_SNK;    // [RULE2]
		end
		// Disabled device parks as an unattached sink
		if (pins.enable_low) begin
			next_state = port_role_pkg::ST_UNATT_SNK;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			state <= port_role_pkg::ST_UNATT_SNK;                              // [RULE8]
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Terminations, orientation and status

	logic next_orientation;

	// Normal wiring: 1 for CC2; swapped wiring: 0 for CC2, 1 for CC1
	assign next_orientation = pins.cc2_active ^ CC_SWAPPED_I;                 // [RULE5]

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			CC_PULLDOWN_O <= 1'b1;                                             // [RULE7]
			CC_PULLUP_O   <= 1'b0;
		end else begin
			CC_PULLDOWN_O <= (next_state == port_role_pkg::ST_UNATT_SNK) ||
				(next_state == port_role_pkg::ST_ATT_SNK);                     // [RULE7]
			CC_PULLUP_O   <= (next_state == port_role_pkg::ST_UNATT_SRC) ||
				(next_state == port_role_pkg::ST_ATT_SRC);
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			PLUG_ORIENTATION_O <= 1'b0;
			ORIENTATION_OUT_O  <= 1'b0;
		end else if (cc_any && (state == port_role_pkg::ST_UNATT_SNK ||
				state == port_role_pkg::ST_UNATT_SRC ||
				state == port_role_pkg::ST_ATT_SRC ||
				state == port_role_pkg::ST_ATT_SNK)) begin
			PLUG_ORIENTATION_O <= next_orientation;                            // [RULE5]
			ORIENTATION_OUT_O  <= next_orientation;                            // [RULE4]
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ATTACH_STATE_O <= port_role_pkg::ST_UNATT_SNK;
			ATTACHED_O     <= 1'b0;
		end else begin
			ATTACH_STATE_O <= next_state;
			ATTACHED_O     <= (next_state == port_role_pkg::ST_ATT_SNK) ||
				(next_state == port_role_pkg::ST_ATT_SRC);                     // [RULE11]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Change alert, open drain

	logic status_change;

	assign status_change = (next_state != state) ||
		(cc_any && next_orientation != PLUG_ORIENTATION_O) ||
		(ROLE_SELECT_WRITE_I && ROLE_SELECT_I != ROLE_SELECT_O) ||
		(SOFT_RESET_I && ROLE_SELECT_O != port_role_pkg::ROLE_RESET);

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			CHANGE_ALERT_OUT_OE_N_O <= 1'b1;
		end else if (status_change) begin
			CHANGE_ALERT_OUT_OE_N_O <= 1'b0;                                   // [RULE3]
		end else if (ALERT_CLEAR_I) begin
			CHANGE_ALERT_OUT_OE_N_O <= 1'b1;
		end
	end

	// Open drain only ever drives low
	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			CHANGE_ALERT_OUT_O <= 1'b0;
		end else begin
			CHANGE_ALERT_OUT_O <= 1'b0;
		end
	end

endmodule

// ### sim/port_role_sva.sv
// Port-level checks for the port-role control block
module port_role_sva (
	// Clock, reset and pins
	input wire logic       CORE_CLK_I,
	input wire logic       RESET_I,
	input wire logic       CHIP_ENABLE_LOW_I,
	input wire logic       VBUS_DETECT_I,
	input wire logic       CC1_ACTIVE_I,
	input wire logic       CC2_ACTIVE_I,
	input wire logic       BUS_ID_STRAP_PULLED_I,
	input wire logic       BUS_ID_STRAP_HIGH_I,
	input wire logic [1:0] ROLE_SELECT_I,
	input wire logic       ROLE_SELECT_WRITE_I,
	input wire logic       SOFT_RESET_I,
	// Observed outputs
	input wire logic [1:0] ROLE_SELECT_O,
	input wire logic [3:0] ATTACH_STATE_O,
	input wire logic       ATTACHED_O,
	input wire logic       PLUG_ORIENTATION_O,
	input wire logic       MANAGEMENT_MODE_O,
	input wire logic [6:0] SLAVE_ADDRESS_O,
	input wire logic       CC_PULLDOWN_O,
	input wire logic       CC_PULLUP_O,
	input wire logic       ORIENTATION_OUT_O,
	input wire logic       CHANGE_ALERT_OUT_O,
	input wire logic       CHANGE_ALERT_OUT_OE_N_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);
	wire wr = ROLE_SELECT_WRITE_I && !SOFT_RESET_I && !CHIP_ENABLE_LOW_I;
	////////////////////////////////////////////////////////////////
	a_sink_role: assert property (wr && ROLE_SELECT_I == 2'h1 |=>
		ROLE_SELECT_O == 2'h1 && ATTACH_STATE_O == 4'h1) else $error("sink role missed");
	a_source_role: assert property (wr && ROLE_SELECT_I == 2'h2 |=>
		ROLE_SELECT_O == 2'h2 && ATTACH_STATE_O == 4'h2) else $error("source role missed");
	a_soft_reset: assert property (SOFT_RESET_I |=>
		ROLE_SELECT_O == 2'h0 && ATTACH_STATE_O == 4'h1) else $error("soft reset ignored");
	a_alert_on_write: assert property (wr && ROLE_SELECT_I != ROLE_SELECT_O |=>
		!CHANGE_ALERT_OUT_OE_N_O && !CHANGE_ALERT_OUT_O) else $error("alert not raised");
	a_mux_follows: assert property (ORIENTATION_OUT_O == PLUG_ORIENTATION_O)
		else $error("mux direction differs");
	a_term_match: assert property (CC_PULLDOWN_O != CC_PULLUP_O &&
		CC_PULLUP_O == (ATTACH_STATE_O[1] | ATTACH_STATE_O[3])) else $error("bad terminations");
	a_sink_attach: assert property ($rose(ATTACH_STATE_O[2]) |->
		$past(VBUS_DETECT_I, 4)) else $error("sink attach without vbus");
	a_source_attach: assert property ($rose(ATTACH_STATE_O[3]) |->
		$past(CC1_ACTIVE_I | CC2_ACTIVE_I, 4)) else $error("source attach without cc");
	a_state_onehot: assert property ($onehot(ATTACH_STATE_O) &&
		ATTACHED_O == (ATTACH_STATE_O[2] | ATTACH_STATE_O[3])) else $error("bad state");
	a_strap_addr: assert property ($past(!RESET_I) |->
		MANAGEMENT_MODE_O == BUS_ID_STRAP_PULLED_I &&
		SLAVE_ADDRESS_O == (BUS_ID_STRAP_HIGH_I ? 7'h67 : 7'h47)) else $error("bad strap");
	c_sink_att: cover property ($rose(ATTACH_STATE_O[2]));
	c_src_att: cover property ($rose(ATTACH_STATE_O[3]));
	c_soft: cover property (SOFT_RESET_I && ROLE_SELECT_WRITE_I);
endmodule

bind typec_port_role_control port_role_sva port_role_sva_i (
	.CORE_CLK_I              (CORE_CLK_I),
	.RESET_I                 (RESET_I),
	.CHIP_ENABLE_LOW_I       (CHIP_ENABLE_LOW_I),
	.VBUS_DETECT_I           (VBUS_DETECT_I),
	.CC1_ACTIVE_I            (CC1_ACTIVE_I),
	.CC2_ACTIVE_I            (CC2_ACTIVE_I),
	.BUS_ID_STRAP_PULLED_I   (BUS_ID_STRAP_PULLED_I),
	.BUS_ID_STRAP_HIGH_I     (BUS_ID_STRAP_HIGH_I),
	.ROLE_SELECT_I           (ROLE_SELECT_I),
	.ROLE_SELECT_WRITE_I     (ROLE_SELECT_WRITE_I),
	.SOFT_RESET_I            (SOFT_RESET_I),
	.ROLE_SELECT_O           (ROLE_SELECT_O),
	.ATTACH_STATE_O          (ATTACH_STATE_O),
	.ATTACHED_O              (ATTACHED_O),
	.PLUG_ORIENTATION_O      (PLUG_ORIENTATION_O),
	.MANAGEMENT_MODE_O       (MANAGEMENT_MODE_O),
	.SLAVE_ADDRESS_O         (SLAVE_ADDRESS_O),
	.CC_PULLDOWN_O           (CC_PULLDOWN_O),
	.CC_PULLUP_O             (CC_PULLUP_O),
	.ORIENTATION_OUT_O       (ORIENTATION_OUT_O),
	.CHANGE_ALERT_OUT_O      (CHANGE_ALERT_OUT_O),
	.CHANGE_ALERT_OUT_OE_N_O (CHANGE_ALERT_OUT_OE_N_O)
);

// ### sim/port_partner_model.sv
// Far-end port partner: powers VBUS as a source, loads one CC as a sink
module port_partner_model (
	// Bench control
	input  wire logic plugged_i,
	input  wire logic use_cc2_i,
	// Terminations shown by our port
	input  wire logic pulldown_i,
	input  wire logic pullup_i,
	// Partner pins
	output logic      vbus_o,
	output logic      cc1_o,
	output logic      cc2_o
);
	assign vbus_o = plugged_i && pulldown_i;
	assign cc1_o  = plugged_i && pullup_i && !use_cc2_i;
	assign cc2_o  = plugged_i && pullup_i && use_cc2_i;
endmodule

// ### sim/typec_port_role_control_bench.sv
// Self-checking bench for the port-role control block
module typec_port_role_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic CORE_CLK_I, RESET_I, CHIP_ENABLE_LOW_I, VBUS_DETECT_I, CC1_ACTIVE_I, CC2_ACTIVE_I;
	logic BUS_ID_STRAP_PULLED_I, BUS_ID_STRAP_HIGH_I, ROLE_SELECT_WRITE_I, SOFT_RESET_I;
	logic CC_SWAPPED_I, ALERT_CLEAR_I, ATTACHED_O, PLUG_ORIENTATION_O, MANAGEMENT_MODE_O;
	logic CC_PULLDOWN_O, CC_PULLUP_O, ORIENTATION_OUT_O, CHANGE_ALERT_OUT_O;
	logic CHANGE_ALERT_OUT_OE_N_O, plugged, use_cc2, orient;
	logic [1:0]  ROLE_SELECT_I, ROLE_SELECT_O;
	logic [3:0]  ATTACH_STATE_O;
	logic [6:0]  SLAVE_ADDRESS_O;
	logic [18:0] note[$];
	int num_errors = 0;
	int tests_run = 0;
	event look;
	wire logic [18:0] obs = {ROLE_SELECT_O, ATTACH_STATE_O, ATTACHED_O, PLUG_ORIENTATION_O,
		CC_PULLDOWN_O, CC_PULLUP_O, CHANGE_ALERT_OUT_OE_N_O, MANAGEMENT_MODE_O, SLAVE_ADDRESS_O};
	typec_port_role_control typec_port_role_control_i (
		.CORE_CLK_I              (CORE_CLK_I),
		.RESET_I                 (RESET_I),
		.CHIP_ENABLE_LOW_I       (CHIP_ENABLE_LOW_I),
		.VBUS_DETECT_I           (VBUS_DETECT_I),
		.CC1_ACTIVE_I            (CC1_ACTIVE_I),
		.CC2_ACTIVE_I            (CC2_ACTIVE_I),
		.BUS_ID_STRAP_PULLED_I   (BUS_ID_STRAP_PULLED_I),
		.BUS_ID_STRAP_HIGH_I     (BUS_ID_STRAP_HIGH_I),
		.ROLE_SELECT_I           (ROLE_SELECT_I),
		.ROLE_SELECT_WRITE_I     (ROLE_SELECT_WRITE_I),
		.SOFT_RESET_I            (SOFT_RESET_I),
		.CC_SWAPPED_I            (CC_SWAPPED_I),
		.ALERT_CLEAR_I           (ALERT_CLEAR_I),
		.ROLE_SELECT_O           (ROLE_SELECT_O),
		.ATTACH_STATE_O          (ATTACH_STATE_O),
		.ATTACHED_O              (ATTACHED_O),
		.PLUG_ORIENTATION_O      (PLUG_ORIENTATION_O),
		.MANAGEMENT_MODE_O       (MANAGEMENT_MODE_O),
		.SLAVE_ADDRESS_O         (SLAVE_ADDRESS_O),
		.CC_PULLDOWN_O           (CC_PULLDOWN_O),
		.CC_PULLUP_O             (CC_PULLUP_O),
		.ORIENTATION_OUT_O       (ORIENTATION_OUT_O),
		.CHANGE_ALERT_OUT_O      (CHANGE_ALERT_OUT_O),
		.CHANGE_ALERT_OUT_OE_N_O (CHANGE_ALERT_OUT_OE_N_O)
	);
	port_partner_model port_partner_model_i (.plugged_i(plugged), .use_cc2_i(use_cc2),
		.pulldown_i(CC_PULLDOWN_O), .pullup_i(CC_PULLUP_O), .vbus_o(VBUS_DETECT_I),
		.cc1_o(CC1_ACTIVE_I), .cc2_o(CC2_ACTIVE_I));
	////////////////////////////////////////////////////////////////
	initial begin
		CORE_CLK_I = 0;
		forever #12.5 CORE_CLK_I = ~CORE_CLK_I;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [18:0] seen, input logic [18:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] outputs expected %h seen %h", exp, seen);
		end
	endtask
	initial begin
		forever begin
			@(look);
			check(obs, note.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge CORE_CLK_I);
		#2;
	endtask
	task automatic want(input logic [1:0] r, input logic [3:0] s, input logic oen);
		note.push_back({r, s, s[2] | s[3], orient, !(s[1] | s[3]), s[1] | s[3], oen,
			BUS_ID_STRAP_PULLED_I, (BUS_ID_STRAP_HIGH_I ? port_role_pkg::ADDR_STRAP_HIGH
			: port_role_pkg::ADDR_STRAP_LOW)});
		-> look;
	endtask
	task automatic role(input logic [1:0] v);
		ROLE_SELECT_I = v;
		ROLE_SELECT_WRITE_I = 1;
		tick(1);
		ROLE_SELECT_WRITE_I = 0;
	endtask
	task automatic clr();
		ALERT_CLEAR_I = 1;
		tick(1);
		ALERT_CLEAR_I = 0;
		tick(1);
	endtask
	task automatic wait_att(input logic v);
		int i;
		for (i = 0; i < 40 && ATTACHED_O !== v; i++)
			tick(1);
		if (i == 40) begin
			num_errors++;
			conclude();
		end
	endtask
	initial begin
		logic chg;
		{CHIP_ENABLE_LOW_I, ROLE_SELECT_WRITE_I, SOFT_RESET_I, ALERT_CLEAR_I} = '0;
		{CC_SWAPPED_I, plugged, use_cc2, orient, BUS_ID_STRAP_HIGH_I} = '0;
		{RESET_I, BUS_ID_STRAP_PULLED_I, ROLE_SELECT_I} = 4'h4 | 4'h8;
		void'($urandom(18));
		tick(4);
		RESET_I = 0;
		tick(2);
		want(2'h0, 4'h1, 1'b1);
		tick(2010);
		clr();
		want(2'h0, 4'h2, 1'b1);
		$display("test 1 done");
		role(2'h1);
		want(2'h1, 4'h1, 1'b0);
		plugged = 1;
		wait_att(1);
		clr();
		want(2'h1, 4'h4, 1'b1);
		plugged = 0;
		wait_att(0);
		$display("test 2 done");
		for (int k = 0; k < 3; k++) begin
			{use_cc2, CC_SWAPPED_I} = 2'($urandom);
			chg = (k == 0);
			clr();
			role(2'h2);
			want(2'h2, 4'h2, !chg);
			clr();
			plugged = 1;
			wait_att(1);
			orient = use_cc2 ^ CC_SWAPPED_I;
			clr();
			want(2'h2, 4'h8, 1'b1);
			plugged = 0;
			wait_att(0);
		end
		$display("test 3 done");
		plugged = 1;
		wait_att(1);
		ROLE_SELECT_I = 2'h1;
		{SOFT_RESET_I, ROLE_SELECT_WRITE_I} = 2'h3;
		tick(1);
		{SOFT_RESET_I, ROLE_SELECT_WRITE_I} = 2'h0;
		want(2'h0, 4'h1, 1'b0);
		plugged = 0;
		tick(10);
		role(2'h2);
		CHIP_ENABLE_LOW_I = 1;
		tick(8);
		clr();
		want(2'h2, 4'h1, 1'b1);
		CHIP_ENABLE_LOW_I = 0;
		tick(8);
		clr();
		want(2'h2, 4'h2, 1'b1);
		$display("test 4 done");
		// Second reset with the strap moved: capture must follow the new strap
		orient = 0;
		{BUS_ID_STRAP_PULLED_I, BUS_ID_STRAP_HIGH_I} = 2'h1;
		RESET_I = 1;
		tick(4);
		RESET_I = 0;
		tick(2);
		want(2'h0, 4'h1, 1'b1);
		$display("test 5 done");
		tick(2);
		conclude();
	end
endmodule
